// File: hw/gisc_config.sv
// Behaviour
// - phase-B high select: 000 low, 001-110 inputs one to six, 111 off.
// - phase-B low select uses the same three-bit encoding.
// - phase-C high select uses the same three-bit encoding.
// - phase-C low select uses the same three-bit encoding.
// - select code 111 turns both source and sink current off.
// - after overcurrent fault: pulldown bit 0 passive pulldown, 1 drive low.
// - comparator two/three hysteresis bit: 0 is 44 mV, 1 is none.
// - charge-pump undervoltage bit: 0 is 0.58, 1 is 0.8 of drive supply.
// - back-EMF gain 0.05/0.1/0.5/1.0 applies only while amp-three gain is 00.
// - each current amp gain code selects 5, 10, 20 or 40 V/V.
// - calibration route bit: 0 reference voltage, 1 the chosen phase.
// - phase code 00x: automatic choice from driver inputs at strobe falling edge.
// - phase code 010: comparator one and two pins give the phase.
// - phase code 011: comparator one and three pins give the phase.
// - fixed codes 100 none, 101 A, 110 B, 111 C.
// - back-EMF hold bit 1: sample only strobe low, PWM on, after delay.
// - current amp hold bit 1: sample only while the strobe is low.
// - delay field 00..11 gives 500, 1000, 2000, 4000 ns.
`timescale 1ns/10ps
module gisc_config
    import gisc_pkg::*;
#(
    parameter int NUM_INPUTS = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic [NUM_INPUTS-1:0] i_logic_input,
    input wire logic i_phase_a_high_drive,
    input wire logic i_phase_a_low_drive,
    input wire logic i_drain_source_overcurrent_fault,
    input wire logic i_shunt_overcurrent_fault,
    input wire logic i_sample_strobe_low,
    input wire logic i_pwm_on,
    input wire logic [1:0] i_gate_transition_delay_field,
    input wire logic i_comparator_one_output_pin,
    input wire logic i_comparator_two_output_pin,
    input wire logic i_comparator_three_output_pin,
    output logic [3:0] o_drive_level,
    output logic [3:0] o_drive_enable,
    output logic [3:0] o_drive_passive_pulldown,
    output logic o_comparator_two_hysteresis,
    output logic o_comparator_three_hysteresis,
    output logic o_charge_pump_undervoltage_level,
    output logic [1:0] o_back_emf_amp_gain,
    output logic o_back_emf_gain_active,
    output logic [1:0] o_current_amp_one_gain,
    output logic [1:0] o_current_amp_two_gain,
    output logic [1:0] o_current_amp_three_gain,
    output logic o_back_emf_cal_input_route,
    output logic [1:0] o_back_emf_phase,
    output logic o_back_emf_sampling,
    output logic [2:0] o_current_amp_sampling
);
    if (NUM_INPUTS != 6) begin : g_bad_inputs
        $error("gisc_config serves exactly six logic inputs");
    end

    // =============================================================
    // registers
    logic [7:0] phase_b_input_select_q;
    logic [7:0] phase_c_input_select_q;
    logic [7:0] amplifier_gain_control_q;
    logic [7:0] sample_phase_control_q;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_b_input_select_q <= GISC_PHASE_B_SEL_RST;
            phase_c_input_select_q <= GISC_PHASE_C_SEL_RST;
            amplifier_gain_control_q <= GISC_AMP_GAIN_RST;
            sample_phase_control_q <= GISC_SAMPLE_PHASE_RST;
        end else if (i_clk_en && i_reg_wr) begin
            if (i_reg_addr == GISC_PHASE_B_SEL_ADDR) begin
                phase_b_input_select_q <= i_reg_wdata;
            end else if (i_reg_addr == GISC_PHASE_C_SEL_ADDR) begin
                phase_c_input_select_q <= i_reg_wdata;
            end else if (i_reg_addr == GISC_AMP_GAIN_ADDR) begin
                amplifier_gain_control_q <= i_reg_wdata;
            end else if (i_reg_addr == GISC_SAMPLE_PHASE_ADDR) begin
                sample_phase_control_q <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= GISC_UNMAPPED_DATA;
        end else if (i_clk_en && i_reg_rd) begin
            if (i_reg_addr == GISC_PHASE_B_SEL_ADDR) begin
                o_reg_rdata <= phase_b_input_select_q;
            end else if (i_reg_addr == GISC_PHASE_C_SEL_ADDR) begin
                o_reg_rdata <= phase_c_input_select_q;
            end else if (i_reg_addr == GISC_AMP_GAIN_ADDR) begin
                o_reg_rdata <= amplifier_gain_control_q;
            end else if (i_reg_addr == GISC_SAMPLE_PHASE_ADDR) begin
                o_reg_rdata <= sample_phase_control_q;
            end else begin
                o_reg_rdata <= GISC_UNMAPPED_DATA;
            end
        end
    end

    // =============================================================
    // field views
    logic [2:0] drive_sel [4];
    logic fault_pulldown_select;
    logic overcurrent_fault;
    logic [2:0] back_emf_phase_choice;

    assign drive_sel[0] = phase_b_input_select_q[GISC_HIGH_SEL_LSB +: 3];
    assign drive_sel[1] = phase_b_input_select_q[GISC_LOW_SEL_LSB +: 3];
    assign drive_sel[2] = phase_c_input_select_q[GISC_HIGH_SEL_LSB +: 3];
    assign drive_sel[3] = phase_c_input_select_q[GISC_LOW_SEL_LSB +: 3];
    assign fault_pulldown_select = phase_b_input_select_q[GISC_MODE_BIT];
    assign overcurrent_fault = i_drain_source_overcurrent_fault | i_shunt_overcurrent_fault;
    assign back_emf_phase_choice = sample_phase_control_q[GISC_PHASE_LSB +: 3];

    // =============================================================
    // gate driver routing, order: B high, B low, C high, C low
    for (genvar d = 0; d < 4; d++) begin : g_drive
        always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                o_drive_level[d] <= 1'b0;
                o_drive_enable[d] <= 1'b0;
                o_drive_passive_pulldown[d] <= 1'b0;
            end else if (i_clk_en) begin
                if (overcurrent_fault) begin
                    // fault pulldown overrides any routing
                    o_drive_level[d] <= 1'b0;
                    o_drive_enable[d] <= fault_pulldown_select;
                    o_drive_passive_pulldown[d] <= !fault_pulldown_select;
                end else if (drive_sel[d] == GISC_SEL_HIGH_Z) begin
                    o_drive_level[d] <= 1'b0;
                    o_drive_enable[d] <= 1'b0;
                    o_drive_passive_pulldown[d] <= 1'b0;
                end else if (drive_sel[d] == GISC_SEL_FORCE_LOW) begin
                    o_drive_level[d] <= 1'b0;
                    o_drive_enable[d] <= 1'b1;
                    o_drive_passive_pulldown[d] <= 1'b0;
                end else begin
                    o_drive_level[d] <= i_logic_input[drive_sel[d] - 3'h1];
                    o_drive_enable[d] <= 1'b1;
                    o_drive_passive_pulldown[d] <= 1'b0;
                end
            end
        end
    end

    // =============================================================
    // static analog controls
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_comparator_two_hysteresis <= GISC_PHASE_B_SEL_RST[GISC_HYST_BIT];
            o_comparator_three_hysteresis <= GISC_PHASE_C_SEL_RST[GISC_HYST_BIT];
            o_charge_pump_undervoltage_level <= GISC_PHASE_C_SEL_RST[GISC_MODE_BIT];
            o_back_emf_amp_gain <= GISC_AMP_GAIN_RST[GISC_BACK_EMF_AMP_GAIN_LSB +: 2];
            o_back_emf_gain_active <= 1'b0;
            o_current_amp_one_gain <= GISC_AMP_GAIN_RST[GISC_AMP1_GAIN_LSB +: 2];
            o_current_amp_two_gain <= GISC_AMP_GAIN_RST[GISC_AMP2_GAIN_LSB +: 2];
            o_current_amp_three_gain <= GISC_AMP_GAIN_RST[GISC_AMP3_GAIN_LSB +: 2];
            o_back_emf_cal_input_route <= 1'b0;
        end else if (i_clk_en) begin
            // 1 means no hysteresis
            o_comparator_two_hysteresis <= phase_b_input_select_q[GISC_HYST_BIT];
            o_comparator_three_hysteresis <= phase_c_input_select_q[GISC_HYST_BIT];
            o_charge_pump_undervoltage_level <= phase_c_input_select_q[GISC_MODE_BIT];
            o_back_emf_amp_gain <= amplifier_gain_control_q[GISC_BACK_EMF_AMP_GAIN_LSB +: 2];
            o_back_emf_gain_active <=
                amplifier_gain_control_q[GISC_AMP3_GAIN_LSB +: 2] == GISC_AMP3_GAIN_LOWEST;
            o_current_amp_one_gain <= amplifier_gain_control_q[GISC_AMP1_GAIN_LSB +: 2];
            o_current_amp_two_gain <= amplifier_gain_control_q[GISC_AMP2_GAIN_LSB +: 2];
            o_current_amp_three_gain <= amplifier_gain_control_q[GISC_AMP3_GAIN_LSB +: 2];
            o_back_emf_cal_input_route <= sample_phase_control_q[GISC_CAL_ROUTE_BIT];
        end
    end

    // =============================================================
    // sample strobe synchroniser
    logic strobe_meta_q;
    logic strobe_sync_q;
    logic strobe_prev_q;
    logic strobe_fall;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strobe_meta_q <= 1'b1;
            strobe_sync_q <= 1'b1;
            strobe_prev_q <= 1'b1;
        end else if (i_clk_en) begin
            strobe_meta_q <= i_sample_strobe_low;
            strobe_sync_q <= strobe_meta_q;
            strobe_prev_q <= strobe_sync_q;
        end
    end

    assign strobe_fall = strobe_prev_q && !strobe_sync_q;

    // =============================================================
    // automatic phase: the one phase whose high and low inputs are both off floats
    logic [1:0] auto_phase_q;
    logic [1:0] floating_phase;
    logic [2:0] phase_idle;

    assign phase_idle[0] = !i_phase_a_high_drive && !i_phase_a_low_drive;
    assign phase_idle[1] = !o_drive_level[0] && !o_drive_level[1];
    assign phase_idle[2] = !o_drive_level[2] && !o_drive_level[3];

    always_comb begin
        if (phase_idle == 3'h1) begin
            floating_phase = GISC_PH_A;
        end else if (phase_idle == 3'h2) begin
            floating_phase = GISC_PH_B;
        end else if (phase_idle == 3'h4) begin
            floating_phase = GISC_PH_C;
        end else begin
            floating_phase = GISC_PH_NONE;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            auto_phase_q <= GISC_PH_NONE;
        end else if (i_clk_en && strobe_fall) begin
            auto_phase_q <= floating_phase;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_back_emf_phase <= GISC_PH_NONE;
        end else if (i_clk_en) begin
            if (back_emf_phase_choice[2:1] == GISC_AUTO_PHASE_TOP) begin
                o_back_emf_phase <= auto_phase_q;
            end else if (back_emf_phase_choice == GISC_PHASE_BY_CMP12) begin
                o_back_emf_phase <= {i_comparator_one_output_pin, i_comparator_two_output_pin};
            end else if (back_emf_phase_choice == GISC_PHASE_BY_CMP13) begin
                o_back_emf_phase <= {i_comparator_one_output_pin, i_comparator_three_output_pin};
            end else begin
                o_back_emf_phase <= back_emf_phase_choice[1:0];
            end
        end
    end

    // =============================================================
    // gate transition delay after PWM turns on
    logic [7:0] gate_delay_cycles;
    logic [7:0] gate_delay_count_q;
    logic gate_delay_done;

    always_comb begin
        case (i_gate_transition_delay_field)
            2'h0: gate_delay_cycles = GISC_GT_500_CYC;
            2'h1: gate_delay_cycles = GISC_GT_1000_CYC;
            2'h2: gate_delay_cycles = GISC_GT_2000_CYC;
            default: gate_delay_cycles = GISC_GT_4000_CYC;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gate_delay_count_q <= 8'h00;
        end else if (i_clk_en) begin
            if (!i_pwm_on) begin
                gate_delay_count_q <= 8'h00;
            end else if (gate_delay_count_q < gate_delay_cycles) begin
                gate_delay_count_q <= gate_delay_count_q + 8'h01;
            end
        end
    end

    // saturating count keeps done high for the rest of the PWM on time
    assign gate_delay_done = gate_delay_count_q >= gate_delay_cycles;

    // =============================================================
    // sample and hold strobes
    logic [2:0] amp_hold_bits;

    assign amp_hold_bits = {sample_phase_control_q[GISC_AMP1_SH_BIT],
                            sample_phase_control_q[GISC_AMP2_SH_BIT],
                            sample_phase_control_q[GISC_AMP3_SH_BIT]};

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_back_emf_sampling <= 1'b1;
            o_current_amp_sampling <= 3'h7;
        end else if (i_clk_en) begin
            o_back_emf_sampling <= !sample_phase_control_q[GISC_BACK_EMF_SAMPLE_HOLD_BIT]
                || (!strobe_sync_q && i_pwm_on && gate_delay_done);
            o_current_amp_sampling <= ~amp_hold_bits | {3{!strobe_sync_q}};
        end
    end

    // =============================================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_write_b;
        i_clk_en && i_reg_wr && i_reg_addr == GISC_PHASE_B_SEL_ADDR;
    endsequence

    sequence s_calm_cycle;
        i_clk_en && !i_drain_source_overcurrent_fault && !i_shunt_overcurrent_fault;
    endsequence

    a_b_high_off: assert property (
        (s_write_b and (i_reg_wdata[6:4] == GISC_SEL_HIGH_Z)) ##1 s_calm_cycle |=> o_drive_enable[0] == 1'b0)
        else $error("phase B high select 111 did not switch driver off");

    a_b_low_forced: assert property (
        s_calm_cycle and (drive_sel[1] == GISC_SEL_FORCE_LOW) |=> o_drive_enable[1] && !o_drive_level[1])
        else $error("phase B low select 000 did not force low");

    a_c_high_route: assert property (
        s_calm_cycle and (drive_sel[2] == 3'h1) |=> o_drive_level[2] == $past(i_logic_input[0]))
        else $error("phase C high select 001 did not route input one");

    a_fault_pulldown: assert property (
        i_clk_en && overcurrent_fault |=> o_drive_level == 4'h0
            && o_drive_enable == {4{$past(fault_pulldown_select)}}
            && o_drive_passive_pulldown == {4{!$past(fault_pulldown_select)}})
        else $error("fault pulldown mode not applied");

    a_gain_gate: assert property (
        i_clk_en |=> o_back_emf_gain_active == ($past(amplifier_gain_control_q[1:0]) == 2'h0))
        else $error("back-EMF gain gate wrong");

    a_phase_fixed: assert property (
        i_clk_en && back_emf_phase_choice[2] |=> o_back_emf_phase == $past(back_emf_phase_choice[1:0]))
        else $error("fixed phase code not followed");

    a_phase_cmp13: assert property (
        i_clk_en && back_emf_phase_choice == 3'h3 |=>
            o_back_emf_phase == {$past(i_comparator_one_output_pin), $past(i_comparator_three_output_pin)})
        else $error("comparator one/three phase wrong");

    a_strobe_sync: assert property (
        i_clk_en && !i_sample_strobe_low ##1 i_clk_en ##1 i_clk_en |-> !strobe_sync_q)
        else $error("strobe not synchronised in two cycles");

    a_amp_hold: assert property (
        i_clk_en && amp_hold_bits[2] && strobe_sync_q |=> !o_current_amp_sampling[2])
        else $error("current amp one sampled while strobe high");

    a_gate_delay: assert property (
        i_clk_en && !i_pwm_on ##1 (i_clk_en && i_pwm_on && i_gate_transition_delay_field == 2'h0) [*8]
            |-> !gate_delay_done)
        else $error("gate transition delay ended early");

endmodule : gisc_config

// File: hw/gisc_pkg.sv
// =============================================================
// register map
package gisc_pkg;
    localparam logic [7:0] GISC_PHASE_B_SEL_ADDR = 8'h0B;
    localparam logic [7:0] GISC_PHASE_C_SEL_ADDR = 8'h0C;
    localparam logic [7:0] GISC_AMP_GAIN_ADDR = 8'h0D;
    localparam logic [7:0] GISC_SAMPLE_PHASE_ADDR = 8'h0E;
    localparam logic [7:0] GISC_PHASE_B_SEL_RST = 8'h25;
    localparam logic [7:0] GISC_PHASE_C_SEL_RST = 8'h36;
    localparam logic [7:0] GISC_AMP_GAIN_RST = 8'hAA;
    localparam logic [7:0] GISC_SAMPLE_PHASE_RST = 8'h00;
    localparam logic [7:0] GISC_UNMAPPED_DATA = 8'h00;
    // =============================================================
    // field positions (select regs share one layout)
    localparam int GISC_HYST_BIT = 7;
    localparam int GISC_HIGH_SEL_LSB = 4;
    localparam int GISC_MODE_BIT = 3;
    localparam int GISC_LOW_SEL_LSB = 0;
    localparam int GISC_BACK_EMF_AMP_GAIN_LSB = 6;
    localparam int GISC_AMP1_GAIN_LSB = 4;
    localparam int GISC_AMP2_GAIN_LSB = 2;
    localparam int GISC_AMP3_GAIN_LSB = 0;
    localparam int GISC_CAL_ROUTE_BIT = 7;
    localparam int GISC_PHASE_LSB = 4;
    localparam int GISC_BACK_EMF_SAMPLE_HOLD_BIT = 3;
    localparam int GISC_AMP1_SH_BIT = 2;
    localparam int GISC_AMP2_SH_BIT = 1;
    localparam int GISC_AMP3_SH_BIT = 0;
    // =============================================================
    // codes
    localparam logic [2:0] GISC_SEL_FORCE_LOW = 3'h0;
    localparam logic [2:0] GISC_SEL_HIGH_Z = 3'h7;
    localparam logic [1:0] GISC_AMP3_GAIN_LOWEST = 2'h0;
    localparam logic [1:0] GISC_AUTO_PHASE_TOP = 2'h0;
    localparam logic [2:0] GISC_PHASE_BY_CMP12 = 3'h2;
    localparam logic [2:0] GISC_PHASE_BY_CMP13 = 3'h3;
    localparam logic [1:0] GISC_PH_NONE = 2'h0;
    localparam logic [1:0] GISC_PH_A = 2'h1;
    localparam logic [1:0] GISC_PH_B = 2'h2;
    localparam logic [1:0] GISC_PH_C = 2'h3;
    // =============================================================
    // timing
    localparam int GISC_CLK_PERIOD_NS = 50;
    localparam int GISC_GT_500_NS = 500;
    localparam int GISC_GT_1000_NS = 1000;
    localparam int GISC_GT_2000_NS = 2000;
    localparam int GISC_GT_4000_NS = 4000;
    localparam logic [7:0] GISC_GT_500_CYC = 8'((GISC_GT_500_NS + GISC_CLK_PERIOD_NS - 1) / GISC_CLK_PERIOD_NS);
    localparam logic [7:0] GISC_GT_1000_CYC = 8'((GISC_GT_1000_NS + GISC_CLK_PERIOD_NS - 1) / GISC_CLK_PERIOD_NS);
    localparam logic [7:0] GISC_GT_2000_CYC = 8'((GISC_GT_2000_NS + GISC_CLK_PERIOD_NS - 1) / GISC_CLK_PERIOD_NS);
    localparam logic [7:0] GISC_GT_4000_CYC = 8'((GISC_GT_4000_NS + GISC_CLK_PERIOD_NS - 1) / GISC_CLK_PERIOD_NS);
endpackage : gisc_pkg

// File: testbench/gisc_mcu_model.sv
`timescale 1ns/10ps
// =============================================================
// microcontroller end of the register link
module gisc_mcu_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_reg_rdata,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // one strobe per access; idle lines show the inverse so stale values never match by luck
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        @(negedge i_ref_clk);
        o_reg_wr = wr;
        o_reg_rd = ~wr;
        o_reg_addr = addr;
        o_reg_wdata = wdata;
        @(negedge i_ref_clk);
        rdata = i_reg_rdata;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = ~addr;
        o_reg_wdata = ~wdata;
    endtask : xfer
endmodule : gisc_mcu_model

// File: testbench/gisc_config_tb.sv
`timescale 1ns/10ps
module gisc_config_tb
    import gisc_pkg::*;
();
    // =============================================================
    // stimulus, reference model and design
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic wr, rd;
    logic [7:0] addr, wdata, rdata, rv;
    logic [5:0] lin = 6'h00;
    logic pa_hi = 1'b0, pa_lo = 1'b0, ds_f = 1'b0, sh_f = 1'b0, strobe_low = 1'b1, pwm = 1'b0;
    logic c1 = 1'b0, c2 = 1'b0, c3 = 1'b0;
    logic [1:0] gt = 2'h0;
    logic [3:0] lvl, en, pas, el, ee;
    logic hy2, hy3, cpuv, gact, cal, bsmp;
    logic [1:0] bgain, g1, g2, g3, ph;
    logic [2:0] csmp;
    int fail_count = 0;
    int checked = 0;
    int seed = 32'hA892;
    int regs[4] = '{GISC_PHASE_B_SEL_RST, GISC_PHASE_C_SEL_RST, GISC_AMP_GAIN_RST, GISC_SAMPLE_PHASE_RST};
    int cd[4];
    int cyc;
    always #25 ref_clk = ~ref_clk;
    gisc_mcu_model mcu (.i_ref_clk(ref_clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_addr(addr), .o_reg_wdata(wdata));
    gisc_config #(.NUM_INPUTS(6)) dut (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_clk_en(clk_en),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_logic_input(lin), .i_phase_a_high_drive(pa_hi), .i_phase_a_low_drive(pa_lo),
        .i_drain_source_overcurrent_fault(ds_f), .i_shunt_overcurrent_fault(sh_f),
        .i_sample_strobe_low(strobe_low), .i_pwm_on(pwm), .i_gate_transition_delay_field(gt),
        .i_comparator_one_output_pin(c1), .i_comparator_two_output_pin(c2), .i_comparator_three_output_pin(c3),
        .o_drive_level(lvl), .o_drive_enable(en), .o_drive_passive_pulldown(pas),
        .o_comparator_two_hysteresis(hy2), .o_comparator_three_hysteresis(hy3),
        .o_charge_pump_undervoltage_level(cpuv), .o_back_emf_amp_gain(bgain), .o_back_emf_gain_active(gact),
        .o_current_amp_one_gain(g1), .o_current_amp_two_gain(g2), .o_current_amp_three_gain(g3),
        .o_back_emf_cal_input_route(cal), .o_back_emf_phase(ph), .o_back_emf_sampling(bsmp),
        .o_current_amp_sampling(csmp));
    // =============================================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] unused;
        mcu.xfer(1'b1, a, d, unused);
        if (a >= GISC_PHASE_B_SEL_ADDR && a <= GISC_SAMPLE_PHASE_ADDR) regs[int'(a) - 11] = d;
        tick(2);
    endtask : wreg
    // four mapped registers, then one address past the map
    task automatic readall();
        logic [7:0] got;
        for (int a = 0; a < 5; a++) begin
            mcu.xfer(1'b0, 8'(11 + a), 8'h00, got);
            check(got, (a < 4) ? 8'(regs[a]) : GISC_UNMAPPED_DATA, "register read");
        end
    endtask : readall
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // =============================================================
    // scenarios
    initial begin
        #3000000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        reset_n = 1'b1;
        tick(1);
        readall();
        // every selector code on every driver, fields staggered so all four differ
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 4; k++) cd[k] = (i + 3 * k) % 8;
            lin = 6'($random(seed));
            rv = 8'($random(seed));
            wreg(GISC_PHASE_B_SEL_ADDR, {rv[7], 3'(cd[0]), 1'b0, 3'(cd[1])});
            wreg(GISC_PHASE_C_SEL_ADDR, {rv[6], 3'(cd[2]), rv[5], 3'(cd[3])});
            for (int k = 0; k < 4; k++) begin
                ee[k] = (cd[k] != 7);
                el[k] = (cd[k] == 0 || cd[k] == 7) ? 1'b0 : lin[cd[k] - 1];
            end
            check({en, pas}, {ee, 4'h0}, "drive enable");
            check(lvl & ee, el, "drive level");
            check({hy2, hy3, cpuv}, rv[7:5], "hysteresis and undervoltage");
        end
        wreg(GISC_PHASE_B_SEL_ADDR, 8'h08);
        ds_f = 1'b1;
        tick(2);
        check({lvl, en, pas}, 12'h0F0, "fault drives low");
        ds_f = 1'b0;
        sh_f = 1'b1;
        wreg(GISC_PHASE_B_SEL_ADDR, 8'h00);
        check({lvl, en, pas}, 12'h00F, "fault passive pulldown");
        sh_f = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rv = 8'($random(seed)) & ((i == 0) ? 8'hFC : 8'hFF);
            wreg(GISC_AMP_GAIN_ADDR, rv);
            check({bgain, g1, g2, g3}, rv, "gains");
            check(gact, rv[1:0] == 2'h0, "back-emf gain in use");
        end
        for (int p = 0; p < 8; p++) begin
            rv = 8'($random(seed));
            {c1, c2, c3} = rv[2:0];
            wreg(GISC_SAMPLE_PHASE_ADDR, {rv[7], 3'(p), 4'h0});
            tick(2);
            check({cal, bsmp, csmp}, {rv[7], 4'hF}, "route and sampling");
            if (p >= 2) check(ph, (p == 2) ? {c1, c2} : (p == 3) ? {c1, c3} : 2'(p - 4), "phase");
        end
        wreg(GISC_SAMPLE_PHASE_ADDR, 8'h4F);
        pwm = 1'b1;
        strobe_low = 1'b0;
        tick(4);
        check({bsmp, csmp}, 4'h7, "strobe sampling before delay");
        tick(16);
        check(bsmp, 1'b1, "back-emf sampling after delay");
        strobe_low = 1'b1;
        tick(5);
        check({bsmp, csmp}, 4'h0, "hold with strobe high");
        // remaining delay codes, strobe held low so only the gate delay gates sampling
        strobe_low = 1'b0;
        for (int g = 1; g < 4; g++) begin
            pwm = 1'b0;
            gt = 2'(g);
            tick(4);
            cyc = (g == 1) ? int'(GISC_GT_1000_CYC) : (g == 2) ? int'(GISC_GT_2000_CYC) : int'(GISC_GT_4000_CYC);
            pwm = 1'b1;
            tick(cyc);
            check(bsmp, 1'b0, "back-emf held inside gate delay");
            tick(2);
            check(bsmp, 1'b1, "back-emf sampling after gate delay");
        end
        strobe_low = 1'b1;
        // phase B both off, A and C driven: automatic choice is B
        wreg(GISC_PHASE_B_SEL_ADDR, 8'h00);
        wreg(GISC_PHASE_C_SEL_ADDR, 8'h11);
        wreg(GISC_SAMPLE_PHASE_ADDR, 8'h00);
        lin = 6'h3F;
        pa_hi = 1'b1;
        strobe_low = 1'b0;
        tick(6);
        check(ph, GISC_PH_B, "automatic phase");
        wreg(8'h0A, 8'hFF);
        // clock enable low: the write and the input change must both be ignored
        clk_en = 1'b0;
        mcu.xfer(1'b1, GISC_PHASE_B_SEL_ADDR, 8'hFF, rv);
        lin = 6'h00;
        tick(2);
        check(lvl, 4'hC, "frozen while clock enable low");
        clk_en = 1'b1;
        readall();
        print_verdict();
    end
endmodule : gisc_config_tb
